// ===== rtl/ccsr_top.v
// clock configuration and scratch register group
`timescale 1ns/100ps
`include "ccsr_consts.vh"
module ccsr_top (
  input wire CORE_CLK_I,
  input wire NRST_I,
  input wire POWER_GOOD_N_I,
  input wire [11:0] ADDR_I,
  input wire WR_I,
  input wire RD_I,
  input wire [3:0] BE_I,
  input wire [31:0] WDATA_I,
  input wire [2:0] BUS_SPEED_SELECT_PINS_I,
  input wire [2:0] MEM_FREQ_STRAP_I,
  input wire HALF_MODE_I,
  output reg [31:0] RDATA_O,
  output reg RVALID_O,
  output wire DYN_SWITCH_EN_O,
  output wire HALF_CLK_INVERT_O,
  output reg HOST_PLL_SHUTDOWN_O,
  output wire MEM_FREQ_VALID_O
);
  // ****************************************
  // register map slots
  // ****************************************
  localparam [2:0] SLOT_CLK_CFG = 3'h0;
  localparam [2:0] SLOT_UNIT_PWR1 = 3'h1;
  localparam [2:0] SLOT_CLK_UNIT = 3'h2;
  localparam [2:0] SLOT_SCRATCH = 3'h3;
  localparam [2:0] SLOT_UNIT_PWR2 = 3'h4;
  localparam [2:0] SLOT_HGI1 = 3'h5;
  localparam [2:0] SLOT_HGI2 = 3'h6;
  localparam [2:0] SLOT_NONE = 3'h7;
  localparam SLOT_COUNT = 7;
  // offsets packed one slot per field, slot 0 in the low bits
  localparam [SLOT_COUNT*`CCSR_ADDR_W-1:0] SLOT_OFFSETS = {
    `CCSR_OFF_HGI2,
    `CCSR_OFF_HGI1,
    `CCSR_OFF_UNIT_PWR2,
    `CCSR_OFF_SCRATCH,
    `CCSR_OFF_CLK_UNIT,
    `CCSR_OFF_UNIT_PWR1,
    `CCSR_OFF_CLK_CFG
  };

  // ****************************************
  // reset and bus qualifiers
  // ****************************************
  wire rst_any;
  wire wr_ok;
  wire [SLOT_COUNT-1:0] hit;
  // either reset returns the ordinary registers to their defaults
  assign rst_any = !NRST_I || !POWER_GOOD_N_I;
  // writes are ignored while any reset is applied
  assign wr_ok = WR_I && !rst_any;

  // one exact-offset comparator per mapped register
  genvar g;
  generate
    for (g = 0; g < SLOT_COUNT; g = g + 1) begin : g_hit
      assign hit[g] = ADDR_I == SLOT_OFFSETS[g*`CCSR_ADDR_W +: `CCSR_ADDR_W];
    end
  endgenerate

  // ****************************************
  // lane and decode helpers
  // ****************************************
  // expand byte enables to a bit mask
  function [31:0] be_mask;
    input [3:0] be;
    begin
      be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  // merge a 32-bit word under a bit mask
  function [31:0] merge32;
    input [31:0] old;
    input [31:0] wd;
    input [31:0] m;
    begin
      merge32 = (old & ~m) | (wd & m);
    end
  endfunction

  // merge a 16-bit word under two byte enables
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] wd;
    input [1:0] be;
    reg [15:0] m;
    begin
      m = {{8{be[1]}}, {8{be[0]}}};
      merge16 = (old & ~m) | (wd & m);
    end
  endfunction

  // lowest hit slot, or the none code when nothing is hit
  function [2:0] slot_of;
    input [SLOT_COUNT-1:0] h;
    integer k;
    begin
      slot_of = SLOT_NONE;
      for (k = SLOT_COUNT - 1; k >= 0; k = k - 1) begin
        if (h[k]) begin
          slot_of = k[2:0];
        end
      end
    end
  endfunction

  // ****************************************
  // state
  // ****************************************
  reg [31:0] clk_cfg_reg;
  reg [31:0] clk_cfg_next;
  reg [15:0] unit_pwr1_reg;
  reg [15:0] unit_pwr1_next;
  reg [15:0] clk_unit_reg;
  reg [15:0] clk_unit_next;
  reg [15:0] unit_pwr2_reg;
  reg [15:0] unit_pwr2_next;
  reg [31:0] hgi1_reg;
  reg [31:0] hgi1_next;
  reg [31:0] hgi2_reg;
  reg [31:0] hgi2_next;
  reg [2:0] mem_strap_reg;
  reg [2:0] mem_strap_next;
  reg [2:0] hb_reg;
  reg [2:0] hb_next;
  reg straps_taken_reg;
  reg straps_taken_next;
  reg pll_off_next;
  reg [31:0] rd_next;
  wire [15:0] scratch;
  wire mem_valid;
  wire hb_valid;

  // ****************************************
  // strap decode and scratch word
  // ****************************************
  ccsr_strap_decode u_dec (
    .mem_code_i(mem_strap_reg),
    .hb_code_i(hb_reg),
    .mem_valid_o(mem_valid),
    .hb_valid_o(hb_valid)
  );

  // sees power good only, so ordinary reset leaves it alone
  ccsr_scratch u_scr (
    .clk_i(CORE_CLK_I),
    .power_good_n_i(POWER_GOOD_N_I),
    .wr_i(wr_ok && hit[SLOT_SCRATCH]),
    .be_i(BE_I[1:0]),
    .wdata_i(WDATA_I[15:0]),
    .data_o(scratch)
  );

  // ****************************************
  // next values of the writable registers
  // ****************************************
  always @* begin
    clk_cfg_next = clk_cfg_reg;
    unit_pwr1_next = unit_pwr1_reg;
    clk_unit_next = clk_unit_reg;
    unit_pwr2_next = unit_pwr2_reg;
    hgi1_next = hgi1_reg;
    hgi2_next = hgi2_reg;
    if (wr_ok) begin
      if (hit[SLOT_CLK_CFG]) begin
        clk_cfg_next = merge32(clk_cfg_reg, WDATA_I, be_mask(BE_I) & `CCSR_WR_MASK_CLK_CFG);
      end
      if (hit[SLOT_UNIT_PWR1]) begin
        unit_pwr1_next = merge16(unit_pwr1_reg, WDATA_I[15:0], BE_I[1:0]);
      end
      // a 16-bit register at +2 takes the upper lanes
      if (hit[SLOT_CLK_UNIT]) begin
        clk_unit_next = merge16(clk_unit_reg, WDATA_I[31:16], BE_I[3:2]);
      end
      if (hit[SLOT_UNIT_PWR2]) begin
        unit_pwr2_next = merge16(unit_pwr2_reg, WDATA_I[15:0], BE_I[1:0]);
      end
      if (hit[SLOT_HGI1]) begin
        hgi1_next = merge32(hgi1_reg, WDATA_I, be_mask(BE_I));
      end
      if (hit[SLOT_HGI2]) begin
        hgi2_next = merge32(hgi2_reg, WDATA_I, be_mask(BE_I));
      end
    end
  end

  // ****************************************
  // writable registers
  // ****************************************
  always @(posedge CORE_CLK_I) begin
    if (rst_any) begin
      clk_cfg_reg <= `CCSR_RST_CLK_CFG;
      unit_pwr1_reg <= `CCSR_RST_UNIT_PWR1;
      clk_unit_reg <= `CCSR_RST_CLK_UNIT;
      unit_pwr2_reg <= `CCSR_RST_UNIT_PWR2;
      hgi1_reg <= `CCSR_RST_HGI;
      hgi2_reg <= `CCSR_RST_HGI;
    end else begin
      clk_cfg_reg <= clk_cfg_next;
      unit_pwr1_reg <= unit_pwr1_next;
      clk_unit_reg <= clk_unit_next;
      unit_pwr2_reg <= unit_pwr2_next;
      hgi1_reg <= hgi1_next;
      hgi2_reg <= hgi2_next;
    end
  end

  // ****************************************
  // strap capture after reset release
  // ****************************************
  always @* begin
    // live mirror of bus speed select pins
    hb_next = BUS_SPEED_SELECT_PINS_I;
    mem_strap_next = mem_strap_reg;
    straps_taken_next = 1'b1;
    if (!straps_taken_reg) begin
      mem_strap_next = MEM_FREQ_STRAP_I;
    end
    // reserved code stops host PLL, once the mirror holds real pins
    pll_off_next = straps_taken_reg && !hb_valid;
  end

  always @(posedge CORE_CLK_I) begin
    if (rst_any) begin
      straps_taken_reg <= 1'b0;
      mem_strap_reg <= `CCSR_RST_STRAP;
      hb_reg <= `CCSR_RST_STRAP;
      HOST_PLL_SHUTDOWN_O <= 1'b0;
    end else begin
      straps_taken_reg <= straps_taken_next;
      mem_strap_reg <= mem_strap_next;
      hb_reg <= hb_next;
      HOST_PLL_SHUTDOWN_O <= pll_off_next;
    end
  end

  // ****************************************
  // control outputs
  // ****************************************
  // dynamic switching enable
  assign DYN_SWITCH_EN_O = clk_cfg_reg[`CCSR_BIT_DYN_EN];
  assign HALF_CLK_INVERT_O = clk_cfg_reg[`CCSR_BIT_POL_INV] && HALF_MODE_I;
  assign MEM_FREQ_VALID_O = mem_valid;

  // ****************************************
  // read path
  // ****************************************
  wire [2:0] rd_slot;
  assign rd_slot = slot_of(hit);
  always @* begin
    rd_next = `CCSR_RD_IDLE;
    case (rd_slot)
      SLOT_CLK_CFG: begin
        rd_next = clk_cfg_reg;
        // strap code in the memory field
        rd_next[`CCSR_MEM_HI:`CCSR_MEM_LO] = mem_strap_reg;
        // mirrored pins in the host-bus field
        rd_next[`CCSR_HB_HI:`CCSR_HB_LO] = hb_reg;
      end
      SLOT_UNIT_PWR1: begin
        // a word read at +0 also returns the +2 register in the upper lanes
        rd_next = {clk_unit_reg, unit_pwr1_reg};
      end
      SLOT_CLK_UNIT: begin
        rd_next = {clk_unit_reg, `CCSR_ZERO16};
      end
      SLOT_SCRATCH: begin
        rd_next = {`CCSR_ZERO16, scratch};
      end
      SLOT_UNIT_PWR2: begin
        rd_next = {`CCSR_ZERO16, unit_pwr2_reg};
      end
      SLOT_HGI1: begin
        rd_next = hgi1_reg;
      end
      SLOT_HGI2: begin
        rd_next = hgi2_reg;
      end
      // unmapped offsets read zero
      default: begin
        rd_next = `CCSR_RD_IDLE;
      end
    endcase
  end

  // read data is registered and stands until the next read or reset
  always @(posedge CORE_CLK_I) begin
    if (rst_any) begin
      RDATA_O <= `CCSR_RD_IDLE;
      RVALID_O <= 1'b0;
    end else begin
      RVALID_O <= RD_I;
      if (RD_I) begin
        RDATA_O <= rd_next;
      end
    end
  end
endmodule

// ===== rtl/ccsr_consts.vh
// constants for the clock configuration and scratch register block
// Overview of operation
// - clock configuration bit 14 turns hardware dynamic host-bus frequency switching on or off
// - clock configuration bit 7 inverts half-rate host clock polarity entering half mode
// - bits 6:4 report strap memory frequency; 011 is 533, 100 is 667
// - bits 2:0 mirror bus speed select pins; 001 533, 011 667, 010 800
// - a reserved bus speed select code shuts down the host clock PLL
// - sixteen bit scratch word is plain storage with no other effect
// - scratch word clears to zero on power good reset only, kept otherwise
`ifndef CCSR_CONSTS_VH
`define CCSR_CONSTS_VH
`define CCSR_ADDR_W 12
`define CCSR_OFF_CLK_CFG 12'hc00
`define CCSR_OFF_UNIT_PWR1 12'hc14
`define CCSR_OFF_CLK_UNIT 12'hc16
`define CCSR_OFF_SCRATCH 12'hc1c
`define CCSR_OFF_UNIT_PWR2 12'hc20
`define CCSR_OFF_HGI1 12'hc34
`define CCSR_OFF_HGI2 12'hc38
`define CCSR_RST_CLK_CFG 32'h00000200
`define CCSR_RST_UNIT_PWR1 16'h0223
`define CCSR_RST_CLK_UNIT 16'h00a0
`define CCSR_RST_SCRATCH 16'h0000
`define CCSR_RST_UNIT_PWR2 16'h0001
`define CCSR_RST_HGI 32'h00000000
`define CCSR_RST_STRAP 3'h0
`define CCSR_RD_IDLE 32'h00000000
`define CCSR_ZERO16 16'h0000
`define CCSR_BIT_DYN_EN 14
`define CCSR_BIT_POL_INV 7
`define CCSR_MEM_HI 6
`define CCSR_MEM_LO 4
`define CCSR_HB_HI 2
`define CCSR_HB_LO 0
`define CCSR_MEM_533 3'h3
`define CCSR_MEM_667 3'h4
`define CCSR_HB_533 3'h1
`define CCSR_HB_667 3'h3
`define CCSR_HB_800 3'h2
`define CCSR_WR_MASK_CLK_CFG 32'h00004080
`endif

// ===== rtl/ccsr_strap_decode.v
// decoder for memory and host-bus frequency strap codes
`timescale 1ns/100ps
`include "ccsr_consts.vh"
module ccsr_strap_decode (
  input wire [2:0] mem_code_i,
  input wire [2:0] hb_code_i,
  output wire mem_valid_o,
  output wire hb_valid_o
);
  assign mem_valid_o = (mem_code_i == `CCSR_MEM_533) || (mem_code_i == `CCSR_MEM_667);
  assign hb_valid_o = (hb_code_i == `CCSR_HB_533) || (hb_code_i == `CCSR_HB_667) ||
                      (hb_code_i == `CCSR_HB_800);
endmodule

// ===== rtl/ccsr_scratch.v
// sticky scratch word, cleared by power good only
`timescale 1ns/100ps
`include "ccsr_consts.vh"
module ccsr_scratch (
  input wire clk_i,
  input wire power_good_n_i,
  input wire wr_i,
  input wire [1:0] be_i,
  input wire [15:0] wdata_i,
  output reg [15:0] data_o
);
  always @(posedge clk_i) begin
    if (!power_good_n_i) begin
      data_o <= `CCSR_RST_SCRATCH;
    end else if (wr_i) begin
      if (be_i[0]) begin
        data_o[7:0] <= wdata_i[7:0];
      end
      if (be_i[1]) begin
        data_o[15:8] <= wdata_i[15:8];
      end
    end
  end
endmodule

// ===== testbench/ccsr_props.sv
// assertion checker for the clock configuration register group
`timescale 1ns/100ps
module ccsr_props (
  input wire CORE_CLK_I,
  input wire NRST_I,
  input wire POWER_GOOD_N_I,
  input wire [11:0] ADDR_I,
  input wire WR_I,
  input wire RD_I,
  input wire [3:0] BE_I,
  input wire [31:0] WDATA_I,
  input wire [2:0] BUS_SPEED_SELECT_PINS_I,
  input wire HALF_MODE_I,
  input wire [31:0] RDATA_O,
  input wire RVALID_O,
  input wire DYN_SWITCH_EN_O,
  input wire HALF_CLK_INVERT_O,
  input wire HOST_PLL_SHUTDOWN_O,
  input wire MEM_FREQ_VALID_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I || !POWER_GOOD_N_I);
  wire [2:0] pins = BUS_SPEED_SELECT_PINS_I;
  wire cfg_wr = WR_I && ADDR_I == 12'hc00;
  wire cfg_rd = RD_I && ADDR_I == 12'hc00;
  wire hb_ok = pins inside {3'h1, 3'h2, 3'h3};
  sequence hb_bad3; !hb_ok [*3]; endsequence
  sequence hb_good3; hb_ok [*3]; endsequence
  sequence sk_wr_rd; WR_I && ADDR_I == 12'hc1c && BE_I[1:0] == 2'h3 ##1 RD_I && ADDR_I == 12'hc1c; endsequence
  a_dyn_write: assert property (cfg_wr && BE_I[1] |=> DYN_SWITCH_EN_O == $past(WDATA_I[14]))
    else $error("switch enable not written");
  a_dyn_hold: assert property (!cfg_wr |=> $stable(DYN_SWITCH_EN_O))
    else $error("switch enable changed");
  a_inv_write: assert property (cfg_wr && BE_I[0] ##1 HALF_MODE_I |-> HALF_CLK_INVERT_O == $past(WDATA_I[7]))
    else $error("invert not written");
  a_inv_gate: assert property (!HALF_MODE_I |-> !HALF_CLK_INVERT_O)
    else $error("invert outside half mode");
  a_mem_valid: assert property (cfg_rd |=> MEM_FREQ_VALID_O == (RDATA_O[6:4] inside {3'h3, 3'h4}))
    else $error("memory code validity");
  a_hb_mirror: assert property (cfg_rd && $stable(pins) |=> RDATA_O[2:0] == $past(pins))
    else $error("bus code not mirrored");
  a_pll_bad: assert property (hb_bad3 |-> HOST_PLL_SHUTDOWN_O)
    else $error("pll not shut down");
  a_pll_good: assert property (hb_good3 |-> !HOST_PLL_SHUTDOWN_O)
    else $error("pll shut down");
  a_sk_rw: assert property (sk_wr_rd |=> RDATA_O[15:0] == $past(WDATA_I[15:0], 2))
    else $error("scratch readback");
  a_rsv_bits: assert property (cfg_rd |=> RVALID_O && RDATA_O[31:15] == 17'h0 && RDATA_O[13:8] == 6'h02 && !RDATA_O[3])
    else $error("reserved bits");
endmodule
bind ccsr_top ccsr_props u_props (.CORE_CLK_I(CORE_CLK_I), .NRST_I(NRST_I), .POWER_GOOD_N_I(POWER_GOOD_N_I),
  .ADDR_I(ADDR_I), .WR_I(WR_I), .RD_I(RD_I), .BE_I(BE_I), .WDATA_I(WDATA_I), .HALF_MODE_I(HALF_MODE_I),
  .BUS_SPEED_SELECT_PINS_I(BUS_SPEED_SELECT_PINS_I), .RDATA_O(RDATA_O), .RVALID_O(RVALID_O),
  .DYN_SWITCH_EN_O(DYN_SWITCH_EN_O), .HALF_CLK_INVERT_O(HALF_CLK_INVERT_O),
  .HOST_PLL_SHUTDOWN_O(HOST_PLL_SHUTDOWN_O), .MEM_FREQ_VALID_O(MEM_FREQ_VALID_O));

// ===== testbench/ccsr_top_tb.sv
// self-checking bench for the clock configuration register group
`timescale 1ns/100ps
module ccsr_top_tb;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg pg_n = 1'b0;
  reg [11:0] addr = 12'h0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [3:0] be = 4'h0;
  reg [31:0] wdata = 32'h0;
  reg [2:0] pins = 3'h1;
  reg [2:0] strap = 3'h3;
  reg half = 1'b0;
  wire [31:0] rdata;
  wire rvalid, dyn, inv, pll_off, mem_ok;
  integer err_count = 0;
  integer compares = 0;
  integer i;
  always #10 clk = ~clk;
  ccsr_top dut (.CORE_CLK_I(clk), .NRST_I(nrst), .POWER_GOOD_N_I(pg_n), .ADDR_I(addr), .WR_I(wr), .RD_I(rd),
    .BE_I(be), .WDATA_I(wdata), .BUS_SPEED_SELECT_PINS_I(pins), .MEM_FREQ_STRAP_I(strap), .HALF_MODE_I(half),
    .RDATA_O(rdata), .RVALID_O(rvalid), .DYN_SWITCH_EN_O(dyn), .HALF_CLK_INVERT_O(inv),
    .HOST_PLL_SHUTDOWN_O(pll_off), .MEM_FREQ_VALID_O(mem_ok));
  // ****************
  // access tasks
  // ****************
  task chk(input [31:0] seen, input [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // pg high clears the scratch word as well
  task do_reset(input pg);
    nrst <= 1'b0;
    pg_n <= ~pg;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    pg_n <= 1'b1;
    @(posedge clk);
  endtask
  task wr_reg(input [11:0] a, input [3:0] b, input [31:0] d);
    addr <= a;
    be <= b;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input [11:0] a, input [31:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
    chk({31'h0, rvalid}, 32'h1);
    @(posedge clk);
  endtask
  task wrap_up;
    $display("mismatches %0d, compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge clk);
    err_count = err_count + 1;
    wrap_up;
  end
  initial begin
    do_reset(1'b1);
    rd_reg(12'hc00, 32'h00000231);
    rd_reg(12'hc14, 32'h00a00223);
    rd_reg(12'hc16, 32'h00a00000);
    rd_reg(12'hc20, 32'h00000001);
    rd_reg(12'hc34, 32'h0);
    rd_reg(12'hc38, 32'h0);
    wr_reg(12'hc04, 4'hf, 32'hffffffff);
    rd_reg(12'hc04, 32'h0);
    half <= 1'b1;
    wr_reg(12'hc00, 4'hf, 32'hffffffff);
    rd_reg(12'hc00, 32'h000042b1);
    chk({30'h0, dyn, inv}, 32'h3);
    half <= 1'b0;
    @(negedge clk);
    chk({30'h0, dyn, inv}, 32'h2);
    @(posedge clk);
    wr_reg(12'hc00, 4'h1, 32'h0);
    half <= 1'b1;
    rd_reg(12'hc00, 32'h00004231);
    chk({30'h0, dyn, inv}, 32'h2);
    wr_reg(12'hc00, 4'hf, 32'h0);
    for (i = 0; i < 8; i = i + 1) begin
      pins <= i[2:0];
      repeat (3) @(posedge clk);
      rd_reg(12'hc00, {25'h4, 3'h3, 1'b0, i[2:0]});
      chk({31'h0, pll_off}, {31'h0, !(i == 1 || i == 2 || i == 3)});
    end
    pins <= 3'h1;
    for (i = 3; i < 6; i = i + 1) begin
      strap <= i[2:0];
      do_reset(1'b0);
      rd_reg(12'hc00, {25'h4, i[2:0], 4'h1});
      chk({31'h0, mem_ok}, {31'h0, i != 5});
    end
    wr_reg(12'hc1c, 4'h3, 32'h0000beef);
    rd_reg(12'hc1c, 32'h0000beef);
    wr_reg(12'hc1c, 4'h1, 32'h00001234);
    rd_reg(12'hc1c, 32'h0000be34);
    rd_reg(12'hc00, 32'h00000251);
    do_reset(1'b0);
    rd_reg(12'hc1c, 32'h0000be34);
    do_reset(1'b1);
    rd_reg(12'hc1c, 32'h0);
    wrap_up;
  end
endmodule
